// ==== verilog/mat_consts.svh ====
`ifndef MAT_CONSTS_SVH
`define MAT_CONSTS_SVH
// system clocks per instruction cycle
`define MAT_CLKS_PER_ICYC 4
`define MAT_CLK_MHZ 200
// register byte addresses
`define MAT_ADDR_CMD 8'h00
`define MAT_ADDR_OPND 8'h04
`define MAT_ADDR_ACC 8'h08
`define MAT_ADDR_FLAGS 8'h0C
`define MAT_ADDR_RESULT 8'h10
`define MAT_ADDR_STATUS 8'h14
// command register fields
`define MAT_CMD_OP_LSB 0
`define MAT_CMD_BIT_LSB 8
`define MAT_CMD_PCL_BIT 12
`define MAT_CMD_MEMDST_BIT 13
// flag register bit positions
`define MAT_FLG_C 0
`define MAT_FLG_AC 1
`define MAT_FLG_Z 2
`define MAT_FLG_OV 3
// reset values
`define MAT_ACC_RST 8'h00
`define MAT_FLAGS_RST 4'h0
// axi responses
`define MAT_RESP_OKAY 2'b00
`define MAT_RESP_SLVERR 2'b10
`endif

// ==== verilog/mat_pkg.sv ====
package mat_pkg;
  // operation codes written to the command register
  typedef enum logic [4:0] {
    OP_ADD = 5'h00,
    OP_ADC = 5'h01,
    OP_SUB = 5'h02,
    OP_SBC = 5'h03,
    OP_DAA = 5'h04,
    OP_AND = 5'h05,
    OP_OR = 5'h06,
    OP_XOR = 5'h07,
    OP_CPL = 5'h08,
    OP_INC = 5'h09,
    OP_DEC = 5'h0A,
    OP_SETB = 5'h0B,
    OP_CLRB = 5'h0C,
    OP_RR = 5'h0D,
    OP_RL = 5'h0E,
    OP_RRC = 5'h0F,
    OP_RLC = 5'h10,
    OP_JMP = 5'h11,
    OP_CALL = 5'h12,
    OP_RET = 5'h13,
    OP_TABRD = 5'h14,
    OP_SKZ = 5'h15
  } mat_op_e;
  // execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } mat_state_e;
endpackage : mat_pkg

// ==== verilog/mat_alu_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mat_consts.svh"
module mat_alu_core
  import mat_pkg::*;
#(
  parameter int CLKS_PER_ICYC = `MAT_CLKS_PER_ICYC,
  parameter int PC_W = 15
) (
  input wire logic SYS_CLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);

  // ---------------- register state ----------------
  logic [7:0] acc_reg; // accumulator
  logic [7:0] opnd_reg; // memory operand or immediate
  logic [7:0] result_reg; // value written back to memory location
  logic [3:0] flags_reg; // ov, z, ac, c
  logic [PC_W-1:0] pc_reg; // program counter of the modelled core
  logic [PC_W-1:0] ret_reg; // saved return address, one level
  logic [PC_W-1:0] target_reg; // jump target taken from the high half of the starting command write
  logic [15:0] cmd_reg; // latched command word
  logic busy_reg; // execution in progress
  logic mem_we_reg; // last op wrote the memory location
  logic [3:0] icyc_cnt_reg; // instruction cycles taken by last op
  logic [7:0] clk_cnt_reg; // system clocks spent in current op
  // no down counter of cycles left: the end is found from the count taken
  logic [1:0] phase_reg; // position inside the instruction cycle
  mat_state_e state_reg;

  // ---------------- axi write channel ----------------
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic start_pulse;

  // address and data may arrive in either order; each is latched then held
  assign wr_go = aw_hold_reg && w_hold_reg && !S_AXI_BVALID_O;
  // a write to the command register while idle starts an operation
  assign start_pulse = wr_go && (aw_addr_reg == `MAT_ADDR_CMD) && w_strb_reg[0] && !busy_reg;

  // address capture
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      S_AXI_AWREADY_O <= 1'b0;
    end else if (wr_go) begin
      aw_hold_reg <= 1'b0;
      S_AXI_AWREADY_O <= 1'b0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR_I;
      S_AXI_AWREADY_O <= 1'b0;
    end else begin
      S_AXI_AWREADY_O <= !aw_hold_reg; // ready whenever no address is held, without waiting for valid
    end
  end

  // data capture
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      S_AXI_WREADY_O <= 1'b0;
    end else if (wr_go) begin
      w_hold_reg <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA_I;
      w_strb_reg <= S_AXI_WSTRB_I;
      S_AXI_WREADY_O <= 1'b0;
    end else begin
      S_AXI_WREADY_O <= !w_hold_reg;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `MAT_RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID_O <= 1'b1;
      case (aw_addr_reg)
        `MAT_ADDR_CMD, `MAT_ADDR_OPND, `MAT_ADDR_ACC, `MAT_ADDR_FLAGS: begin
          S_AXI_BRESP_O <= `MAT_RESP_OKAY;
        end
        `MAT_ADDR_RESULT, `MAT_ADDR_STATUS: begin
          S_AXI_BRESP_O <= `MAT_RESP_OKAY; // read-only, write ignored
        end
        default: begin
          S_AXI_BRESP_O <= `MAT_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // ---------------- datapath ----------------
  mat_op_e op;
  logic [2:0] bit_sel;
  logic pcl_write; // instruction also writes program counter low byte
  logic mem_dst; // result goes to memory, not accumulator
  assign op = mat_op_e'(cmd_reg[`MAT_CMD_OP_LSB +: 5]);
  assign bit_sel = cmd_reg[`MAT_CMD_BIT_LSB +: 3];
  assign pcl_write = cmd_reg[`MAT_CMD_PCL_BIT];
  assign mem_dst = cmd_reg[`MAT_CMD_MEMDST_BIT];

  logic [7:0] alu_res;
  logic [3:0] flags_next;
  logic wr_mem; // result goes to memory location
  logic wr_acc; // result goes to accumulator
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic cin;
  logic [7:0] bcd_lo;
  logic bcd_c;

  // combinational alu; results wrap modulo 256 by the 8-bit target
  always_comb begin
    alu_res = acc_reg;
    flags_next = flags_reg;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    sum9 = 9'h000;
    sum5 = 5'h00;
    cin = 1'b0;
    bcd_lo = 8'h00;
    bcd_c = 1'b0;
    case (op)
      OP_ADD, OP_ADC: begin
        cin = (op == OP_ADC) ? flags_reg[`MAT_FLG_C] : 1'b0;
        sum9 = {1'b0, acc_reg} + {1'b0, opnd_reg} + {8'h00, cin};
        sum5 = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]} + {4'h0, cin};
        alu_res = sum9[7:0];
        flags_next[`MAT_FLG_C] = sum9[8];
        flags_next[`MAT_FLG_AC] = sum5[4];
        flags_next[`MAT_FLG_OV] = (acc_reg[7] == opnd_reg[7]) && (alu_res[7] != acc_reg[7]);
        flags_next[`MAT_FLG_Z] = (alu_res == 8'h00);
        wr_mem = mem_dst;
        wr_acc = !mem_dst;
      end
      OP_SUB, OP_SBC: begin
        // carry set means no borrow; borrow-in is the inverted carry
        cin = (op == OP_SBC) ? flags_reg[`MAT_FLG_C] : 1'b1;
        sum9 = {1'b0, acc_reg} + {1'b0, ~opnd_reg} + {8'h00, cin};
        sum5 = {1'b0, acc_reg[3:0]} + {1'b0, ~opnd_reg[3:0]} + {4'h0, cin};
        alu_res = sum9[7:0];
        flags_next[`MAT_FLG_C] = sum9[8];
        flags_next[`MAT_FLG_AC] = sum5[4];
        flags_next[`MAT_FLG_OV] = (acc_reg[7] != opnd_reg[7]) && (alu_res[7] != acc_reg[7]);
        flags_next[`MAT_FLG_Z] = (alu_res == 8'h00);
        wr_mem = mem_dst;
        wr_acc = !mem_dst;
      end
      OP_DAA: begin
        // adjust low then high nibble; only carry changes
        bcd_lo = ((acc_reg[3:0] > 4'h9) || flags_reg[`MAT_FLG_AC]) ? acc_reg + 8'h06 : acc_reg;
        bcd_c = (bcd_lo[7:4] > 4'h9) || flags_reg[`MAT_FLG_C] ||
                ((acc_reg[3:0] > 4'h9) && (acc_reg[7:4] == 4'hF));
        alu_res = bcd_c ? bcd_lo + 8'h60 : bcd_lo;
        flags_next[`MAT_FLG_C] = bcd_c;
        wr_mem = 1'b1;
      end
      OP_AND, OP_OR, OP_XOR, OP_CPL: begin
        if (op == OP_AND) begin
          alu_res = acc_reg & opnd_reg;
        end else if (op == OP_OR) begin
          alu_res = acc_reg | opnd_reg;
        end else if (op == OP_XOR) begin
          alu_res = acc_reg ^ opnd_reg;
        end else begin
          alu_res = ~opnd_reg;
        end
        flags_next[`MAT_FLG_Z] = (alu_res == 8'h00);
        wr_mem = mem_dst;
        wr_acc = !mem_dst;
      end
      OP_INC, OP_DEC: begin
        alu_res = (op == OP_INC) ? opnd_reg + 8'h01 : opnd_reg - 8'h01;
        flags_next[`MAT_FLG_Z] = (alu_res == 8'h00);
        wr_mem = mem_dst;
        wr_acc = !mem_dst;
      end
      OP_SETB, OP_CLRB: begin
        // read-modify-write of a single bit
        alu_res = opnd_reg;
        alu_res[bit_sel] = (op == OP_SETB);
        wr_mem = 1'b1;
      end
      OP_RR, OP_RL: begin
        alu_res = (op == OP_RR) ? {opnd_reg[0], opnd_reg[7:1]} : {opnd_reg[6:0], opnd_reg[7]};
        wr_mem = mem_dst; // flags untouched
        wr_acc = !mem_dst;
      end
      OP_RRC, OP_RLC: begin
        if (op == OP_RRC) begin
          alu_res = {flags_reg[`MAT_FLG_C], opnd_reg[7:1]};
          flags_next[`MAT_FLG_C] = opnd_reg[0];
        end else begin
          alu_res = {opnd_reg[6:0], flags_reg[`MAT_FLG_C]};
          flags_next[`MAT_FLG_C] = opnd_reg[7];
        end
        wr_mem = mem_dst;
        wr_acc = !mem_dst;
      end
      default: begin
        alu_res = acc_reg; // control ops leave data untouched
      end
    endcase
  end

  // instruction cycles the op needs
  logic [2:0] icyc_need;
  always_comb begin
    case (op)
      OP_JMP, OP_CALL, OP_RET, OP_TABRD: icyc_need = 3'd2;
      OP_SKZ: icyc_need = (opnd_reg == 8'h00) ? 3'd2 : 3'd1;
      default: icyc_need = pcl_write ? 3'd2 : 3'd1;
    endcase
  end

  // sequencer: whole instruction cycles of four system clocks
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      phase_reg <= 2'b00; // the counts below restart on every start write
      icyc_cnt_reg <= 4'h0;
      clk_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_pulse) begin
            state_reg <= ST_EXEC;
            busy_reg <= 1'b1;
            phase_reg <= 2'b00;
            icyc_cnt_reg <= 4'h0;
            clk_cnt_reg <= 8'h00;
          end
        end
        ST_EXEC: begin
          clk_cnt_reg <= clk_cnt_reg + 8'h01;
          phase_reg <= phase_reg + 2'b01;
          if (phase_reg == 2'(CLKS_PER_ICYC - 1)) begin
            icyc_cnt_reg <= icyc_cnt_reg + 4'h1;
            if (icyc_cnt_reg + 4'h1 >= {1'b0, icyc_need}) begin
              state_reg <= ST_IDLE;
              busy_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  logic commit; // last clock of the final instruction cycle
  assign commit = (state_reg == ST_EXEC) && (phase_reg == 2'(CLKS_PER_ICYC - 1)) &&
                  (icyc_cnt_reg + 4'h1 >= {1'b0, icyc_need});

  // architectural state; software writes are refused while busy
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      acc_reg <= `MAT_ACC_RST;
      flags_reg <= `MAT_FLAGS_RST;
      opnd_reg <= 8'h00;
      result_reg <= 8'h00;
      cmd_reg <= 16'h0000;
      mem_we_reg <= 1'b0;
    end else if (commit) begin
      flags_reg <= flags_next;
      mem_we_reg <= wr_mem;
      if (wr_acc) begin
        acc_reg <= alu_res;
      end
      if (wr_mem) begin
        result_reg <= alu_res;
      end
    end else if (wr_go && !busy_reg && w_strb_reg[0]) begin
      case (aw_addr_reg)
        `MAT_ADDR_CMD: cmd_reg <= w_strb_reg[1] ? w_data_reg[15:0] : {8'h00, w_data_reg[7:0]};
        `MAT_ADDR_OPND: opnd_reg <= w_data_reg[7:0];
        `MAT_ADDR_ACC: acc_reg <= w_data_reg[7:0];
        `MAT_ADDR_FLAGS: flags_reg <= w_data_reg[3:0];
        default: begin
        end
      endcase
    end
  end

  // program counter, call save and return
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      pc_reg <= '0;
      ret_reg <= '0;
      target_reg <= '0;
    end else if (commit) begin
      case (op)
        OP_JMP: pc_reg <= target_reg;
        OP_CALL: begin
          ret_reg <= pc_reg + PC_W'(1);
          pc_reg <= target_reg;
        end
        OP_RET: pc_reg <= ret_reg;
        OP_SKZ: pc_reg <= pc_reg + ((opnd_reg == 8'h00) ? PC_W'(2) : PC_W'(1));
        default: pc_reg <= pcl_write ? {pc_reg[PC_W-1:8], alu_res} : pc_reg + PC_W'(1);
      endcase
    end else if (start_pulse) begin
      target_reg <= PC_W'({w_data_reg[31:16]});
    end
  end

  // ---------------- axi read channel ----------------
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= `MAT_RESP_OKAY;
    end else if (S_AXI_RVALID_O) begin
      if (S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= `MAT_RESP_OKAY;
      case (S_AXI_ARADDR_I)
        `MAT_ADDR_CMD: S_AXI_RDATA_O <= {16'h0000, cmd_reg};
        `MAT_ADDR_OPND: S_AXI_RDATA_O <= {24'h000000, opnd_reg};
        `MAT_ADDR_ACC: S_AXI_RDATA_O <= {24'h000000, acc_reg};
        `MAT_ADDR_FLAGS: S_AXI_RDATA_O <= {28'h0000000, flags_reg};
        `MAT_ADDR_RESULT: S_AXI_RDATA_O <= {24'h000000, result_reg};
        `MAT_ADDR_STATUS: S_AXI_RDATA_O <= {16'(pc_reg), 6'h00, mem_we_reg, busy_reg,
                                            icyc_cnt_reg, 4'h0};
        default: begin
          S_AXI_RDATA_O <= 32'h00000000;
          S_AXI_RRESP_O <= `MAT_RESP_SLVERR;
        end
      endcase
    end else begin
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // ---------------- assertions ----------------
  a_icyc_four_clks: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    $fell(busy_reg) |-> (clk_cnt_reg == ({4'h0, icyc_cnt_reg} << 2)))
    else $error("instruction length not a multiple of four clocks");
  a_branch_two_cyc: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && (op == OP_CALL || op == OP_JMP)) |-> (icyc_cnt_reg == 4'h1))
    else $error("branch did not take two cycles");
  a_pcl_extra_cyc: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && pcl_write && op == OP_ADD) |-> (icyc_cnt_reg == 4'h1))
    else $error("pcl write missed extra cycle");
  a_skip_cycles: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && op == OP_SKZ) |-> (icyc_cnt_reg == ((opnd_reg == 8'h00) ? 4'h1 : 4'h0)))
    else $error("skip cycle count wrong");
  a_add_result: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && op == OP_ADD && !mem_dst) |=> (acc_reg == 8'($past(acc_reg) + $past(opnd_reg))))
    else $error("add result wrong");
  a_carry_out: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && op == OP_ADD) |=>
      (flags_reg[`MAT_FLG_C] == ({1'b0, $past(acc_reg)} + {1'b0, $past(opnd_reg)} > 9'd255)))
    else $error("carry flag wrong");
  a_logic_zero: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && op == OP_AND) |=> (flags_reg[`MAT_FLG_Z] == (result_reg == 8'h00 && mem_we_reg
      || acc_reg == 8'h00 && !mem_we_reg)))
    else $error("zero flag wrong after logic op");
  a_logic_flags: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && (op == OP_XOR || op == OP_INC)) |=>
      (flags_reg[2:0] & 3'b011) == ($past(flags_reg[2:0]) & 3'b011) &&
      flags_reg[`MAT_FLG_OV] == $past(flags_reg[`MAT_FLG_OV]))
    else $error("logic op touched arithmetic flags");
  a_bit_rmw: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && op == OP_SETB) |=> ((result_reg | (8'h01 << $past(bit_sel))) ==
      ($past(opnd_reg) | (8'h01 << $past(bit_sel)))) && result_reg[$past(bit_sel)])
    else $error("bit set disturbed other bits");
  a_rotate_noflag: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && (op == OP_RR || op == OP_RL)) |=> $stable(flags_reg))
    else $error("plain rotate changed flags");
  a_call_return: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
    (commit && op == OP_CALL) |=> (ret_reg == $past(pc_reg) + PC_W'(1)))
    else $error("call saved wrong return address");

endmodule : mat_alu_core
`default_nettype wire

// ==== tb/tb_mcu_alu_instruction_timing.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mat_consts.svh"
module tb_mcu_alu_instruction_timing
  import mat_pkg::*;
;
  logic clk; // 200 MHz system clock
  logic srst; // synchronous reset, active high
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [31:0] r_acc, r_flg, r_res, r_st; // results gathered after each op
  int err_total;
  int checks;

  mat_alu_core uut (.SYS_CLK_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready));

  // free-running clock, 5 ns period
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one write; the leading edge keeps two transfers from driving in one time step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0; // address taken, release it
      if (wvalid && wready) wvalid <= 1'h0; // data taken, release it
      if (bvalid === 1'h1) begin
        resp = bresp;
        break;
      end
    end
    bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        d = rdata;
        resp = rresp;
        break;
      end
    end
    rready <= 1'h0;
  endtask : axi_rd

  // command word: target, memory destination, pcl write, bit index, op
  function automatic logic [31:0] cm(input mat_op_e op, input logic md, input logic program_counter_low_byte,
                                     input logic [2:0] b, input logic [15:0] tg);
    return {tg, 2'h0, md, program_counter_low_byte, 1'h0, b, 3'h0, op};
  endfunction : cm

  // poll busy with a bound; an unknown busy ends the wait and fails later
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axi_rd(`MAT_ADDR_STATUS, r_st, rsp);
      n++;
    end while (r_st[8] === 1'h1 && n < 40);
    if (r_st[8] !== 1'h0) begin
      err_total++; // busy never cleared inside the poll limit
    end
  endtask : wait_idle

  task automatic run_op(input logic [31:0] cmd, input logic [7:0] acc, input logic [3:0] flg,
                        input logic [7:0] opnd);
    axi_wr(`MAT_ADDR_ACC, {24'h0, acc}, rsp);
    axi_wr(`MAT_ADDR_FLAGS, {28'h0, flg}, rsp);
    axi_wr(`MAT_ADDR_OPND, {24'h0, opnd}, rsp);
    axi_wr(`MAT_ADDR_CMD, cmd, rsp);
    wait_idle();
    axi_rd(`MAT_ADDR_ACC, r_acc, rsp);
    axi_rd(`MAT_ADDR_FLAGS, r_flg, rsp);
    axi_rd(`MAT_ADDR_RESULT, r_res, rsp);
  endtask : run_op

  // additions: flags are {ov, z, half, c}; mem form must leave acc alone
  task automatic t_add();
    run_op(cm(OP_ADD, 0, 0, 0, 0), 8'h7F, 4'h0, 8'h01);
    chk("add acc", r_acc[7:0], 8'h80);
    chk("add flags", r_flg[3:0], 4'hA);
    chk("add cycles", r_st[7:4], 4'h1);
    run_op(cm(OP_ADD, 0, 0, 0, 0), 8'hFF, 4'h0, 8'h01);
    chk("add wrap", r_acc[7:0], 8'h00);
    chk("add carry", r_flg[3:0], 4'h7);
    run_op(cm(OP_ADD, 1, 0, 0, 0), 8'h12, 4'hF, 8'h34);
    chk("add_into_memory mem", r_res[7:0], 8'h46);
    chk("add_into_memory acc", r_acc[7:0], 8'h12);
    chk("add_into_memory flags", r_flg[3:0], 4'h0);
    chk("add_into_memory wrote", r_st[9], 1'h1);
    run_op(cm(OP_ADC, 0, 0, 0, 0), 8'h0F, 4'h1, 8'h00);
    chk("adc acc", r_acc[7:0], 8'h10);
    chk("adc flags", r_flg[3:0], 4'h2);
    run_op(cm(OP_ADC, 1, 0, 0, 0), 8'hFF, 4'h1, 8'h00);
    chk("adcm mem", r_res[7:0], 8'h00);
    chk("adcm flags", r_flg[3:0], 4'h7);
  endtask : t_add

  // subtractions: carry means no borrow; half carry masked, its sense is open
  task automatic t_sub();
    run_op(cm(OP_SUB, 0, 0, 0, 0), 8'h80, 4'h0, 8'h01);
    chk("sub acc", r_acc[7:0], 8'h7F);
    chk("sub flags", r_flg[3:0] & 4'hD, 4'h9);
    run_op(cm(OP_SUB, 0, 0, 0, 0), 8'h00, 4'h1, 8'h01);
    chk("sub borrow", {r_acc[7:0], r_flg[3:0] & 4'hD}, 12'hFF0);
    run_op(cm(OP_SUB, 1, 0, 0, 0), 8'h05, 4'h0, 8'h05);
    chk("subtract_into_memory mem", {r_res[7:0], r_acc[7:0]}, 16'h0005);
    chk("subtract_into_memory flags", r_flg[3:0] & 4'hD, 4'h5);
    run_op(cm(OP_SBC, 0, 0, 0, 0), 8'h05, 4'h0, 8'h02);
    chk("sbc acc", {r_acc[7:0], r_flg[3:0] & 4'hD}, 12'h021);
    run_op(cm(OP_SBC, 1, 0, 0, 0), 8'h03, 4'h1, 8'h04);
    chk("sbcm mem", {r_res[7:0], r_flg[3:0] & 4'hD}, 12'hFF0);
  endtask : t_sub

  // bcd fixup writes memory and may touch carry only
  task automatic t_bcd();
    run_op(cm(OP_DAA, 1, 0, 0, 0), 8'h0A, 4'hC, 8'h00);
    chk("bcd low", {r_res[7:0], r_acc[7:0], r_flg[3:0]}, 20'h100AC);
    run_op(cm(OP_DAA, 1, 0, 0, 0), 8'hA0, 4'hC, 8'h00);
    chk("bcd high", {r_res[7:0], r_flg[3:0]}, 12'h00D);
  endtask : t_bcd

  // logic and unary ops on both destinations; preset flags other than zero must survive
  task automatic t_logic();
    mat_op_e ops[7] = '{OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC, OP_DEC};
    logic [7:0] av[7] = '{8'hF0, 8'hF0, 8'hF0, 8'h5A, 8'h5A, 8'h5A, 8'h5A};
    logic [7:0] ov[7] = '{8'h0F, 8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'h01, 8'h00};
    logic [7:0] ev[7] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF};
    for (int i = 0; i < 7; i++) begin
      for (int md = 0; md < 2; md++) begin
        run_op(cm(ops[i], md[0], 0, 0, 0), av[i], 4'hB, ov[i]);
        chk("logic flags", r_flg[3:0], {1'h1, ev[i] == 8'h00, 2'h3});
        if (md == 0) begin
          chk("logic acc", r_acc[7:0], ev[i]);
        end else begin
          chk("logic mem", {r_res[7:0], r_acc[7:0]}, {ev[i], av[i]});
        end
      end
    end
  endtask : t_logic

  // every bit index set and cleared; other bits and flags untouched
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      run_op(cm(OP_SETB, 1, 0, b[2:0], 0), 8'h00, 4'h5, 8'h00);
      chk("set bit", {r_res[7:0], r_flg[3:0]}, {8'h01 << b, 4'h5});
      run_op(cm(OP_CLRB, 1, 0, b[2:0], 0), 8'h00, 4'hA, 8'hFF);
      chk("clear bit", {r_res[7:0], r_flg[3:0]}, {~(8'h01 << b), 4'hA});
    end
  endtask : t_bits

  task automatic t_rot();
    run_op(cm(OP_RR, 1, 0, 0, 0), 8'h00, 4'hF, 8'h01);
    chk("rot right", {r_res[7:0], r_flg[3:0]}, 12'h80F);
    run_op(cm(OP_RL, 1, 0, 0, 0), 8'h00, 4'h0, 8'h80);
    chk("rot left", {r_res[7:0], r_flg[3:0]}, 12'h010);
    run_op(cm(OP_RRC, 1, 0, 0, 0), 8'h00, 4'h0, 8'h01);
    chk("rot right c", {r_res[7:0], r_flg[0]}, 9'h001);
    run_op(cm(OP_RLC, 1, 0, 0, 0), 8'h00, 4'h1, 8'h80);
    chk("rot left c", {r_res[7:0], r_flg[0]}, 9'h003);
  endtask : t_rot

  // instruction cycles taken, each of four system clocks
  task automatic t_timing();
    mat_op_e two[4] = '{OP_JMP, OP_CALL, OP_RET, OP_TABRD};
    foreach (two[i]) begin
      run_op(cm(two[i], 0, 0, 0, 16'h0040), 8'h00, 4'h0, 8'h00);
      chk("branch cycles", r_st[7:4], 4'h2);
    end
    run_op(cm(OP_ADD, 0, 1, 0, 0), 8'h01, 4'h0, 8'h01);
    chk("pcl cycles", r_st[7:4], 4'h2);
    run_op(cm(OP_SKZ, 0, 0, 0, 0), 8'h00, 4'h0, 8'h00);
    chk("skip taken", r_st[7:4], 4'h2);
    run_op(cm(OP_SKZ, 0, 0, 0, 0), 8'h00, 4'h0, 8'h01);
    chk("skip not", r_st[7:4], 4'h1);
  endtask : t_timing

  // a jump between call and return must not disturb the saved return point
  task automatic t_call();
    logic [15:0] pc0;
    axi_rd(`MAT_ADDR_STATUS, rd, rsp);
    pc0 = rd[31:16];
    run_op(cm(OP_CALL, 0, 0, 0, 16'h0123), 8'h00, 4'h0, 8'h00);
    chk("call pc", r_st[31:16], 16'h0123);
    run_op(cm(OP_JMP, 0, 0, 0, 16'h0300), 8'h00, 4'h0, 8'h00);
    chk("jump pc", r_st[31:16], 16'h0300);
    run_op(cm(OP_RET, 0, 0, 0, 0), 8'h00, 4'h0, 8'h00);
    chk("ret pc", r_st[31:16], pc0 + 16'h0001);
  endtask : t_call

  // reset values, unmapped place, read-only result, write while busy
  task automatic t_bus();
    axi_rd(`MAT_ADDR_ACC, rd, rsp);
    chk("acc reset", rd, 32'h0);
    axi_rd(`MAT_ADDR_FLAGS, rd, rsp);
    chk("flags reset", rd, 32'h0);
    axi_rd(8'h18, rd, rsp);
    chk("unmapped read", {rsp, rd}, {`MAT_RESP_SLVERR, 32'h0});
    axi_wr(8'h18, 32'h5, rsp);
    chk("unmapped write", rsp, `MAT_RESP_SLVERR);
    axi_wr(`MAT_ADDR_ACC, 32'h11, rsp);
    axi_wr(`MAT_ADDR_CMD, cm(OP_JMP, 0, 0, 0, 16'h0010), rsp);
    axi_wr(`MAT_ADDR_ACC, 32'h22, rsp);
    wait_idle();
    axi_rd(`MAT_ADDR_ACC, rd, rsp);
    chk("busy write", rd[7:0], 8'h11);
    axi_wr(`MAT_ADDR_RESULT, 32'hAA, rsp);
    chk("ro write resp", rsp, `MAT_RESP_OKAY);
  endtask : t_bus

  // watchdog well beyond the expected few thousand cycles
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end

  // main sequence: inputs idle at time zero, reset held three cycles
  initial begin
    err_total = 0;
    checks = 0;
    srst = 1'h1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    t_bus();
    t_add();
    t_sub();
    t_bcd();
    t_logic();
    t_bits();
    t_rot();
    t_timing();
    t_call();
    tally_and_finish();
  end
endmodule : tb_mcu_alu_instruction_timing
`default_nettype wire
